// ==== shared/iop_pkg.sv ====
// Purpose: constants and carrier types for the port-to-fabric routing block
// Assumes: 8-pin port, 32-bit Avalon-MM register window, byte addressing
// Notes: all offsets are byte addresses of aligned words
`default_nettype none
package iop_pkg;
    // ------------------------------------------------------------
    // port shape
    // ------------------------------------------------------------
    localparam int unsigned PINS = 8; // pins per port
    localparam int unsigned OE_LINES = 4; // dynamic enable lines
    localparam int unsigned OE_SEL_W = 2; // bits to pick one enable line
    localparam int unsigned ADDR_W = 5; // byte address width
    localparam int unsigned DATA_W = 32; // bus data width
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_IN_SYNC = 5'h00; // input double-sync select
    localparam logic [4:0] OFS_OUT_SYNC = 5'h04; // output single-sync select
    localparam logic [4:0] OFS_OE_USE = 5'h08; // pin follows a dynamic enable
    localparam logic [4:0] OFS_OE_SEL = 5'h0C; // enable line per pin, 2 bits each
    localparam logic [4:0] OFS_PIN_STATE = 5'h10; // synchronized pin levels, read only
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_IN_SYNC = 8'hFF; // synchronized inputs by default
    localparam logic [7:0] RST_OUT_SYNC = 8'h00; // outputs pass straight through
    localparam logic [7:0] RST_OE_USE = 8'h00; // all pins undriven after reset
    localparam logic [15:0] RST_OE_SEL = 16'h0000; // all pins ganged on line 0
    // ------------------------------------------------------------
    // carrier from the fabric
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] oe; // dynamic output enables
        logic [7:0] data; // pin output data
    } iop_fab_drive_t;
endpackage
`default_nettype wire

// ==== design/iop_sync2.sv ====
// Purpose: two-flop synchronizer for one pin level
// Assumes: d is asynchronous to mclk
// Notes: the first flop feeds only the second
`default_nettype none
module iop_sync2 (
    input wire logic mclk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic d, // asynchronous level
    output logic q // level in mclk domain
);
    logic meta_r; // first stage, may go metastable

    // ------------------------------------------------------------
    // two cascaded stages on the system clock
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== design/iop_port_route.sv ====
// Purpose: routes one 8-pin port to the logic array fabric
// Assumes: fabric signals on mclk; pin inputs asynchronous
// Notes: bypassed paths are combinational by design
//
// What this block does
// - 20 fabric routes: 16 data, 4 enables
// - each pin has input and output route
// - optional single output register stage
// - optional double input synchronizer
// - all sync stages on system clock
// - four dynamic output enable lines
// - enables ganged or up to four individual
// - bypassed input reaches fabric asynchronously
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`default_nettype none
module iop_port_route (
    input wire logic mclk, // system clock, 20 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // low on the accepting cycle
    input wire iop_pkg::iop_fab_drive_t fab_drive, // data and enables from fabric
    output logic [7:0] fab_in, // pin levels toward fabric
    input wire logic [7:0] pin_i, // pin input levels
    output logic [7:0] pin_o, // pin output levels
    output logic [7:0] pin_oe // high while pin is driven
);
    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic [7:0] in_sync_r; // 1: pin input double-synchronized
    logic [7:0] out_sync_r; // 1: pin output registered
    logic [7:0] oe_use_r; // 1: pin follows its enable line
    logic [15:0] oe_sel_r; // enable line index per pin
    logic wait_r; // waitrequest flop
    logic [31:0] rdata_r; // read data flop
    logic [7:0] pin_sync; // synchronized pin levels
    logic [7:0] out_r; // registered output data
    logic [7:0] oe_r; // registered enables
    logic [7:0] oe_pin; // selected enable per pin
    logic bus_req; // read or write pending
    logic bus_take; // request accepted this edge

    assign bus_req = avs_read | avs_write;
    assign bus_take = bus_req & ~wait_r;

    // decode of one pin's enable line, used for all pins
    function automatic logic pick_oe(input logic [3:0] oe, input logic [1:0] sel);
        pick_oe = oe[sel];
    endfunction

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then accept
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 1'b1;
        end else if (bus_req && wait_r) begin
            wait_r <= 1'b0; // accept at next edge
        end else begin
            wait_r <= 1'b1;
        end
    end

    // read data captured during the wait cycle, stands at accept edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && wait_r) begin
            case (avs_address)
                iop_pkg::OFS_IN_SYNC: rdata_r <= {24'h00_0000, in_sync_r};
                iop_pkg::OFS_OUT_SYNC: rdata_r <= {24'h00_0000, out_sync_r};
                iop_pkg::OFS_OE_USE: rdata_r <= {24'h00_0000, oe_use_r};
                iop_pkg::OFS_OE_SEL: rdata_r <= {16'h0000, oe_sel_r};
                iop_pkg::OFS_PIN_STATE: rdata_r <= {24'h00_0000, pin_sync};
                default: rdata_r <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------
    // register writes, taken only at the accept edge
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            in_sync_r <= iop_pkg::RST_IN_SYNC;
            out_sync_r <= iop_pkg::RST_OUT_SYNC;
            oe_use_r <= iop_pkg::RST_OE_USE;
            oe_sel_r <= iop_pkg::RST_OE_SEL;
        end else if (avs_write && bus_take) begin
            case (avs_address)
                iop_pkg::OFS_IN_SYNC: in_sync_r <= avs_writedata[7:0];
                iop_pkg::OFS_OUT_SYNC: out_sync_r <= avs_writedata[7:0];
                iop_pkg::OFS_OE_USE: oe_use_r <= avs_writedata[7:0];
                iop_pkg::OFS_OE_SEL: oe_sel_r <= avs_writedata[15:0];
                default: ; // unmapped and read-only writes ignored
            endcase
        end
    end

    // ------------------------------------------------------------
    // per-pin paths
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            // input path: two flops on mclk, or bypass
            iop_sync2 u_sync (
                .mclk(mclk),
                .rst_b(rst_b),
                .d(pin_i[g]),
                .q(pin_sync[g])
            );
            // bypass is a true async path for combinational feed-through
            assign fab_in[g] = in_sync_r[g] ? pin_sync[g] : pin_i[g];
            // enable line picked from the four shared lines
            assign oe_pin[g] = pick_oe(fab_drive.oe, oe_sel_r[2*g+1:2*g]);
        end
    endgenerate

    // output stage: one register on mclk
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_r <= 8'h00;
            oe_r <= 8'h00;
        end else begin
            out_r <= fab_drive.data;
            oe_r <= oe_pin; // enable kept aligned with data
        end
    end

    // ------------------------------------------------------------
    // pin drive: unregistered pins stay combinational
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_o[i] = out_sync_r[i] ? out_r[i] : fab_drive.data[i];
            pin_oe[i] = oe_use_r[i] & (out_sync_r[i] ? oe_r[i] : oe_pin[i]);
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_req_wait;
        bus_req && wait_r;
    endsequence
    sequence s_accept;
        !wait_r ##1 wait_r;
    endsequence

    a_bus_one_wait: assert property (s_req_wait |=> s_accept)
        else $error("request not accepted after one wait cycle");
    a_write_in_sync: assert property (avs_write && bus_take &&
        avs_address == iop_pkg::OFS_IN_SYNC |=> in_sync_r == $past(avs_writedata[7:0]))
        else $error("input sync select not written");
    a_no_write_wait: assert property (avs_write && wait_r |=>
        in_sync_r == $past(in_sync_r))
        else $error("write took effect before accept");

    generate
        for (g = 0; g < 8; g++) begin : g_chk
            a_in_two_flops: assert property (in_sync_r[g] && $past(in_sync_r[g], 2)
                |-> fab_in[g] == $past(pin_i[g], 2))
                else $error("synchronized input not two cycles late");
            a_in_bypass: assert property (!in_sync_r[g] |-> fab_in[g] == pin_i[g])
                else $error("bypassed input not direct");
            a_out_one_flop: assert property (out_sync_r[g] |->
                pin_o[g] == $past(fab_drive.data[g]))
                else $error("registered output not one cycle late");
            a_out_bypass: assert property (!out_sync_r[g] |->
                pin_o[g] == fab_drive.data[g])
                else $error("bypassed output not direct");
            a_oe_unused: assert property (!oe_use_r[g] |-> !pin_oe[g])
                else $error("pin driven while enable unused");
            a_oe_gang: assert property (oe_use_r[g] && !out_sync_r[g] &&
                oe_sel_r[2*g+1:2*g] == 2'd0 |-> pin_oe[g] == fab_drive.oe[0])
                else $error("ganged pin not following line 0");
        end
    endgenerate
endmodule
`default_nettype wire

// ==== verification/iop_fabric_model.sv ====
// Purpose: fabric-side model feeding port data and dynamic enables
// Assumes: fabric flops run on mclk like the port's sync stages
// Notes: drive values follow bench commands one edge late
`default_nettype none
module iop_fabric_model (
    input wire logic mclk, // system clock
    input wire logic [7:0] want_data, // data asked by bench
    input wire logic [3:0] want_oe, // enables asked by bench
    input wire logic [7:0] fab_in, // pin levels from port
    output var iop_pkg::iop_fab_drive_t fab_drive, // toward port
    output logic [7:0] seen_r // last pin sample taken by fabric
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // fabric flops
    // ----------------------------------------------------------------
    // registered, so no loop back through the bypassed port paths
    always_ff @(posedge mclk) begin
        fab_drive.data <= want_data;
        fab_drive.oe <= want_oe;
    end
    // fabric logic samples fab_in, the synchronized or the bypassed pin level per pin
    always_ff @(posedge mclk) begin
        seen_r <= fab_in;
    end
endmodule
`default_nettype wire

// ==== verification/iop_port_route_tb.sv ====
// Purpose: self-checking bench for the port routing block
// Assumes: one wait cycle per access, sync paths on mclk
// Notes: waitrequest is watched at the falling edge, read data taken at the accept edge
`default_nettype none
module iop_port_route_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_b, avs_read, avs_write, avs_waitrequest; // bus side
    logic [4:0] avs_address; // byte address
    logic [31:0] avs_writedata, avs_readdata, rd; // bus data
    logic [7:0] fab_in, pin_i, pin_o, pin_oe, want_data, exp_oe, seen; // pin side
    logic [3:0] want_oe; // enable command
    logic [15:0] sels [3] = '{16'h0000, 16'h00E4, 16'hFA50}; // ganged, single, pairs
    iop_pkg::iop_fab_drive_t fab_drive; // model to port
    int failures = 0, checked = 0;
    // ----------------------------------------------------------------
    // clock, instances
    // ----------------------------------------------------------------
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    iop_port_route i_dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fab_drive(fab_drive), .fab_in(fab_in), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe));
    iop_fabric_model i_fab (.mclk(mclk), .want_data(want_data), .want_oe(want_oe),
        .fab_in(fab_in), .fab_drive(fab_drive), .seen_r(seen));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one access; the settled level at negedge is what the next rising edge samples
    // no local cycle limit: only the watchdog ends a wait that never answers
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(negedge mclk);
        while (avs_waitrequest !== 1'b0) @(negedge mclk);
        // accept edge: write lands, read data taken, request released
        @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // waitrequest must be high again in the cycle after the accept
        @(negedge mclk);
        chk(avs_waitrequest, 1'b1);
    endtask
    task automatic wrap_up;
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {pin_i, want_data, want_oe} = '0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        bus(0, 5'h00, 0); chk(rd, 32'h0000_00FF);
        bus(0, 5'h04, 0); chk(rd, 32'h0000_0000);
        bus(0, 5'h0C, 0); chk(rd, 32'h0000_0000);
        bus(1, 5'h14, 32'hFFFF_FFFF); bus(0, 5'h14, 0); chk(rd, 32'h0000_0000);
        // input path synchronized: two edges late
        @(posedge mclk) pin_i <= 8'hA5;
        @(negedge mclk) @(negedge mclk) chk(fab_in, 8'h00);
        @(negedge mclk) chk(fab_in, 8'hA5);
        @(negedge mclk) chk(seen, 8'hA5);
        bus(1, 5'h10, 0); bus(0, 5'h10, 0); chk(rd, 32'h0000_00A5);
        // bypassed input shows within the same cycle
        bus(1, 5'h00, 0);
        @(posedge mclk) pin_i <= 8'h5A;
        #1 chk(fab_in, 8'h5A);
        // output path: straight, then one register stage
        @(posedge mclk) want_data <= 8'h3C;
        @(negedge mclk) @(negedge mclk) chk(pin_o, 8'h3C);
        bus(1, 5'h04, 32'h0000_00FF);
        @(posedge mclk) want_data <= 8'hC3;
        @(negedge mclk) @(negedge mclk) chk(pin_o, 8'h3C);
        @(negedge mclk) chk(pin_o, 8'hC3);
        bus(1, 5'h04, 0);
        // every enable pattern under ganged, single and paired mappings
        bus(1, 5'h08, 32'h0000_00FF);
        foreach (sels[s]) begin
            bus(1, 5'h0C, {16'h0000, sels[s]});
            for (int v = 0; v < 16; v++) begin
                for (int p = 0; p < 8; p++) exp_oe[p] = v[sels[s][2*p+:2]];
                @(posedge mclk) want_oe <= v[3:0];
                @(negedge mclk) @(negedge mclk) chk(pin_oe, exp_oe);
            end
        end
        // registered enables trail the fabric by one edge, like the data
        bus(1, 5'h04, 32'h0000_00FF);
        @(posedge mclk) want_oe <= 4'h0;
        @(negedge mclk) @(negedge mclk) chk(pin_oe, 8'hFF);
        @(negedge mclk) chk(pin_oe, 8'h00);
        @(posedge mclk) want_oe <= 4'hF;
        bus(1, 5'h04, 0);
        // pins outside the enable use stay high impedance
        bus(1, 5'h08, 32'h0000_000F);
        @(negedge mclk) chk(pin_oe, 8'h0F);
        bus(0, 5'h0C, 0); chk(rd, 32'h0000_FA50);
        wrap_up();
    end
endmodule
`default_nettype wire
